// ===== design/pnvc_pkg.sv
// Purpose: shared constants for the nonvolatile config/mode link
// Assumes: 125 MHz system clock at both ends
// Notes: all timing counts derive from printed times
`default_nettype none
package pnvc_pkg;
	localparam int MODE_W = 8;
	localparam int SHADOW_W = 20;
	localparam int CNT_W = 24;
	// mode bit positions
	localparam int MB_SHADOW_OUT = 1;
	localparam int MB_MAIN_OUT = 2;
	localparam int MB_PWRDN = 3;
	localparam int MB_CNT_LOAD = 4;
	localparam int MB_MODSEL_OUT = 5;
	localparam int MB_REF_OUT = 6;
	localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
	localparam logic [MODE_W-1:0] MODE_RSVD_MASK = 8'h81;
	localparam logic [SHADOW_W-1:0] STORE_ERASED = 20'hFFFFF;
	localparam logic [SHADOW_W-1:0] SHADOW_RESET = 20'h00000;
	// synchronised pin vector positions on the device side
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_SWR = 2;
	localparam int PIN_STB = 3;
	localparam int PIN_ENN = 4;
	localparam int PIN_SEL = 5;
	localparam int PIN_LOAD = 6;
	localparam int PIN_VNEG = 7;
	localparam int PIN_VPOS = 8;
	localparam int PIN_N = 9;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int LINK_PERIOD_NS = 160;
	localparam int NS_PER_MS = 1000000;
	localparam int PULSE_MS = 25;
	localparam int GAP_MS = 100;
	localparam int PULSE_CYC = PULSE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int GAP_CYC = (GAP_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] HALF_LAST = 24'(SCLK_HALF_CYC - 1);
	// host command word: {op, data}
	localparam int OP_W = 3;
	localparam int CMD_W = OP_W + SHADOW_W;
	localparam int FIFO_DEPTH = 4;
	typedef enum logic [OP_W-1:0] {
		OP_MODE, OP_SHADOW, OP_ERASE, OP_PROG, OP_READ
	} pnvc_op_t;
endpackage
`default_nettype wire

// ===== design/pnvc_link_if.sv
// Purpose: pins between programmer and device
// Assumes: all signals one-way, no shared wires
// Notes: host makes sclk by a divider
`default_nettype none
interface pnvc_link_if;
	logic sclk;
	logic sdata;
	logic s_wr;
	logic mode_stb;
	logic mode_en_n;
	logic nv_select;
	logic nv_load_ctrl;
	logic prog_voltage_neg;
	logic prog_voltage_pos;
	logic sdout;
	modport dev (input sclk, input sdata, input s_wr, input mode_stb,
		input mode_en_n, input nv_select, input nv_load_ctrl,
		input prog_voltage_neg, input prog_voltage_pos, output sdout);
	modport host (output sclk, output sdata, output s_wr,
		output mode_stb, output mode_en_n, output nv_select,
		output nv_load_ctrl, output prog_voltage_neg,
		output prog_voltage_pos, input sdout);
endinterface
`default_nettype wire

// ===== design/pnvc_dev.sv
// Purpose: device end: mode register, shadow register, nv store
// Assumes: link pins are asynchronous, sampled by CLK_SYS
// Notes: nv store modelled as flops, erased value at reset
//
// Overview of operation
// - mode bits apply only on strobe falling edge
// - each function active when its bit is one
// - mode bits ignored while enable pin high
// - programmer keeps enable high until mode written
// - programmer sets at most one output-select bit
// - bits 2,5,6 route main, modulus, reference outputs
// - bit 1 shifts shadow out, LSB first
// - bit 3 powers down all but serial port
// - bit 4 loads counters immediately and continuously
// - store written as all 20 bits at once
// - write ANDs store with shadow register
// - erase: strobe, select, load high, negative pulse
// - programmer loads shadow before writing store
// - write: strobe high, select low, load high, pulse
// - programmer drops load after write pulse
// - programmer avoids needless load toggling before write
// - programmer leaves relay gap between erase and write
// - verify: bit 1 set, 19 clocks, twice
// - shadow LSB on output before first clock
// - programmer holds enable low during readback
// - data captured on rising clock, LSB first
// - shifted-out bits replaced by serial input
// - shadow loads on select rise or load fall
`default_nettype none
module pnvc_dev import pnvc_pkg::*; (
	input wire logic CLK_SYS, // system clock
	input wire logic RESETN, // async reset, active low
	pnvc_link_if.dev LINK, // programmer pins
	input wire logic MAIN_DIV_OUT, // main divider output
	input wire logic MODULUS_SELECT, // prescaler modulus select
	input wire logic REF_DIV_OUT, // reference divider output
	output logic POWER_DOWN, // power down request to core
	output logic CNT_LOAD_CONT, // continuous counter load
	output logic [SHADOW_W-1:0] STORE_Q, // nv store contents
	output logic [SHADOW_W-1:0] SHADOW_Q // shadow register contents
);

	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] prev;
		logic [MODE_W-1:0] mode_sr;
		logic [MODE_W-1:0] mode_buf;
		logic [SHADOW_W-1:0] shadow;
		logic [SHADOW_W-1:0] store;
		logic dout;
		logic pwrdn;
		logic cntld;
	} pnvc_dev_st_t;

	pnvc_dev_st_t cur_ff;
	pnvc_dev_st_t nxt_st;
	logic [PIN_N-1:0] pins;
	logic [PIN_N-1:0] p;
	logic [PIN_N-1:0] rise;
	logic [PIN_N-1:0] fall;
	logic [MODE_W-1:0] act_mode;
	logic readout;

	// gather raw pins into one vector for the synchronisers
	assign pins[PIN_SCLK] = LINK.sclk;
	assign pins[PIN_SDATA] = LINK.sdata;
	assign pins[PIN_SWR] = LINK.s_wr;
	assign pins[PIN_STB] = LINK.mode_stb;
	assign pins[PIN_ENN] = LINK.mode_en_n;
	assign pins[PIN_SEL] = LINK.nv_select;
	assign pins[PIN_LOAD] = LINK.nv_load_ctrl;
	assign pins[PIN_VNEG] = LINK.prog_voltage_neg;
	assign pins[PIN_VPOS] = LINK.prog_voltage_pos;

	// edges come from stage two and its delayed copy only
	assign p = cur_ff.s2;
	assign rise = cur_ff.s2 & ~cur_ff.prev;
	assign fall = ~cur_ff.s2 & cur_ff.prev;

	// enable pin high masks every mode function
	assign act_mode = p[PIN_ENN] ? MODE_RESET : cur_ff.mode_buf;
	assign readout = act_mode[MB_SHADOW_OUT];

	// next-state logic
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = cur_ff.s1;
		nxt_st.prev = cur_ff.s2;

		// serial capture on rising clock, LSB enters first
		if (rise[PIN_SCLK]) begin
			if (!p[PIN_SWR] && !p[PIN_LOAD] && p[PIN_STB]) begin
				nxt_st.mode_sr = {p[PIN_SDATA],
					cur_ff.mode_sr[MODE_W-1:1]};
			end
			// readback shift refills from the data pin
			if ((!p[PIN_SWR] && p[PIN_LOAD]) || readout) begin
				nxt_st.shadow = {p[PIN_SDATA],
					cur_ff.shadow[SHADOW_W-1:1]};
			end
		end

		// buffer isolates core from partial shifts
		if (fall[PIN_STB]) begin
			nxt_st.mode_buf = cur_ff.mode_sr;
		end

		// store copy wins over a shift in the same cycle
		if ((rise[PIN_SEL] && !p[PIN_LOAD]) ||
			(fall[PIN_LOAD] && p[PIN_SEL])) begin
			nxt_st.shadow = cur_ff.store;
		end

		// pulse edge commits; level held for pulse is programmer's job
		if (p[PIN_SWR] && p[PIN_LOAD]) begin
			if (p[PIN_SEL] && rise[PIN_VNEG]) begin
				nxt_st.store = STORE_ERASED;
			end else if (!p[PIN_SEL] && rise[PIN_VPOS]) begin
				nxt_st.store = cur_ff.store & cur_ff.shadow;
			end
		end

		// serial output source; shadow bit 0 shows before any clock
		if (readout) begin
			nxt_st.dout = cur_ff.shadow[0];
		end else if (act_mode[MB_MAIN_OUT]) begin
			nxt_st.dout = MAIN_DIV_OUT;
		end else if (act_mode[MB_MODSEL_OUT]) begin
			nxt_st.dout = MODULUS_SELECT;
		end else if (act_mode[MB_REF_OUT]) begin
			nxt_st.dout = REF_DIV_OUT;
		end else begin
			nxt_st.dout = 1'b0;
		end

		// each function follows its own bit only
		nxt_st.pwrdn = act_mode[MB_PWRDN];
		nxt_st.cntld = act_mode[MB_CNT_LOAD];
	end

	// state register; mode cleared at reset though silicon is unknown
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			// enable pin idles high: no false edge, no unmasked mode
			cur_ff.s1 <= '0;
			cur_ff.s1[PIN_ENN] <= 1'b1;
			cur_ff.s2 <= '0;
			cur_ff.s2[PIN_ENN] <= 1'b1;
			cur_ff.prev <= '0;
			cur_ff.prev[PIN_ENN] <= 1'b1;
			cur_ff.mode_sr <= MODE_RESET;
			cur_ff.mode_buf <= MODE_RESET;
			cur_ff.shadow <= SHADOW_RESET;
			cur_ff.store <= STORE_ERASED;
			cur_ff.dout <= 1'b0;
			cur_ff.pwrdn <= 1'b0;
			cur_ff.cntld <= 1'b0;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// outputs straight from flops
	assign LINK.sdout = cur_ff.dout;
	assign POWER_DOWN = cur_ff.pwrdn;
	assign CNT_LOAD_CONT = cur_ff.cntld;
	assign STORE_Q = cur_ff.store;
	assign SHADOW_Q = cur_ff.shadow;

endmodule
`default_nettype wire

// ===== design/pnvc_host.sv
// Purpose: programmer end: command queue and pin sequencer
// Assumes: device pins sampled at 125 MHz; sclk made here
// Notes: pulse and gap lengths are parameters for simulation
`default_nettype none
module pnvc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RESETN, // async reset, active low
	input wire logic IN_VALID, // write request
	output logic IN_READY, // space free
	input wire logic [W-1:0] IN_DATA, // write word
	output logic OUT_VALID, // word available
	input wire logic OUT_READY, // reader takes word
	output logic [W-1:0] OUT_DATA // head word
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic full;
		logic empty;
	} pnvc_fifo_st_t;
	pnvc_fifo_st_t cur_ff;
	pnvc_fifo_st_t nxt_st;
	logic push;
	logic pop;

	assign push = IN_VALID && !cur_ff.full;
	assign pop = OUT_READY && !cur_ff.empty;

	// pointers wrap at depth, flags kept registered
	always_comb begin
		nxt_st = cur_ff;
		if (push) begin
			nxt_st.mem[cur_ff.wp] = IN_DATA;
			nxt_st.wp = (cur_ff.wp == AW'(DEPTH - 1)) ? '0 :
				cur_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = (cur_ff.rp == AW'(DEPTH - 1)) ? '0 :
				cur_ff.rp + 1'b1;
		end
		nxt_st.cnt = cur_ff.cnt + CW'(push) - CW'(pop);
		nxt_st.full = (nxt_st.cnt == CW'(DEPTH));
		nxt_st.empty = (nxt_st.cnt == '0);
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			cur_ff <= '0;
			cur_ff.empty <= 1'b1;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign IN_READY = !cur_ff.full;
	assign OUT_VALID = !cur_ff.empty;
	assign OUT_DATA = cur_ff.mem[cur_ff.rp];
endmodule

module pnvc_host import pnvc_pkg::*; #(
	parameter int PULSE_CYCLES = PULSE_CYC,
	parameter int GAP_CYCLES = GAP_CYC
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RESETN, // async reset, active low
	pnvc_link_if.host LINK, // device pins
	input wire logic CMD_VALID, // command offered
	output logic CMD_READY, // queue has room
	input wire logic [OP_W-1:0] CMD_OP, // operation code
	input wire logic [SHADOW_W-1:0] CMD_DATA, // mode or shadow data
	output logic BUSY, // sequence in progress
	output logic RD_VALID, // readback word pulse
	output logic [SHADOW_W-1:0] RD_DATA // readback word
);
	typedef enum logic [3:0] {
		H_IDLE, H_SETUP, H_ARM, H_LO, H_HI, H_STB, H_PULSE, H_GAP, H_FIN
	} pnvc_hst_t;
	typedef struct packed {
		pnvc_hst_t st;
		pnvc_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [SHADOW_W-1:0] sr;
		logic [4:0] bitcnt;
		logic [4:0] nbits;
		logic dout_s1;
		logic dout_s2;
		logic sclk, sdata, s_wr, stb, en_n, sel, load, vneg, vpos;
		logic busy;
		logic rd_valid;
	} pnvc_host_st_t;
	pnvc_host_st_t cur_ff;
	pnvc_host_st_t nxt_st;
	logic q_valid;
	logic q_pop;
	logic [CMD_W-1:0] q_data;
	logic half_end;
	logic is_rd;

	// commands queue here so the user need not stall while a pulse runs, until four are queued
	pnvc_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_q (
		.CLK_SYS(CLK_SYS),
		.RESETN(RESETN),
		.IN_VALID(CMD_VALID),
		.IN_READY(CMD_READY),
		.IN_DATA({CMD_OP, CMD_DATA}),
		.OUT_VALID(q_valid),
		.OUT_READY(q_pop),
		.OUT_DATA(q_data)
	);

	assign half_end = (cur_ff.cnt == HALF_LAST);
	assign is_rd = (cur_ff.op == OP_READ);
	assign q_pop = (cur_ff.st == H_IDLE) && q_valid;

	// sequencer: pin changes after H_IDLE wait a half link period, except pulse end (PULSE_CYCLES) and the post-erase load drop (GAP_CYCLES plus a half)
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.dout_s1 = LINK.sdout;
		nxt_st.dout_s2 = cur_ff.dout_s1;
		nxt_st.rd_valid = 1'b0;
		nxt_st.cnt = cur_ff.cnt + 24'h000001;
		case (cur_ff.st)
		H_IDLE: begin
			nxt_st.cnt = '0;
			if (q_valid) begin
				nxt_st.op = pnvc_op_t'(q_data[CMD_W-1:SHADOW_W]);
				nxt_st.sr = q_data[SHADOW_W-1:0];
				nxt_st.bitcnt = '0;
				nxt_st.busy = 1'b1;
				nxt_st.st = H_SETUP;
				nxt_st.nbits = 5'(SHADOW_W);
				case (pnvc_op_t'(q_data[CMD_W-1:SHADOW_W]))
				OP_MODE: begin
					nxt_st.stb = 1'b1;
					nxt_st.nbits = 5'(MODE_W);
					nxt_st.sr[MODE_W-1:0] = q_data[MODE_W-1:0] &
						~MODE_RSVD_MASK; // reserved bits 0 and 7 forced low
				end
				OP_SHADOW: nxt_st.load = 1'b1;
				OP_ERASE, OP_PROG: begin
					nxt_st.s_wr = 1'b1;
					nxt_st.load = 1'b1;
				end
				default: ; // read: select low, load low
				endcase
			end
		end
		H_SETUP: if (half_end) begin
			nxt_st.cnt = '0;
			nxt_st.sdata = cur_ff.sr[0];
			if (cur_ff.op == OP_MODE || cur_ff.op == OP_SHADOW) begin
				nxt_st.st = H_LO;
			end else begin
				// select rises for erase with load high (no reload) and for read with load low (store reloads shadow)
				nxt_st.sel = (cur_ff.op != OP_PROG);
				nxt_st.st = H_ARM;
			end
		end
		H_ARM: if (half_end) begin
			nxt_st.cnt = '0;
			nxt_st.st = is_rd ? H_LO : H_PULSE;
			nxt_st.vneg = (cur_ff.op == OP_ERASE);
			nxt_st.vpos = (cur_ff.op == OP_PROG);
		end
		H_LO: if (half_end) begin
			nxt_st.cnt = '0;
			if (is_rd) begin
				nxt_st.sr = {cur_ff.dout_s2, cur_ff.sr[SHADOW_W-1:1]};
			end
			// last read sample needs no clock: 19 clocks for 20 bits
			if (is_rd && cur_ff.bitcnt == cur_ff.nbits - 5'd1) begin
				nxt_st.st = H_FIN;
			end else begin
				nxt_st.sclk = 1'b1;
				nxt_st.st = H_HI;
			end
		end
		H_HI: if (half_end) begin
			nxt_st.cnt = '0;
			nxt_st.sclk = 1'b0;
			if (!is_rd && cur_ff.bitcnt == cur_ff.nbits - 5'd1) begin
				nxt_st.st = (cur_ff.op == OP_MODE) ? H_STB : H_FIN;
			end else begin
				nxt_st.bitcnt = cur_ff.bitcnt + 5'd1;
				nxt_st.st = H_LO;
				if (!is_rd) begin
					nxt_st.sr = cur_ff.sr >> 1;
					nxt_st.sdata = cur_ff.sr[1];
				end
			end
		end
		H_STB: if (half_end) begin
			nxt_st.cnt = '0;
			nxt_st.stb = 1'b0;
			nxt_st.en_n = 1'b0;
			nxt_st.st = H_FIN;
		end
		H_PULSE: if (cur_ff.cnt == 24'(PULSE_CYCLES - 1)) begin
			nxt_st.cnt = '0;
			nxt_st.vneg = 1'b0;
			nxt_st.vpos = 1'b0;
			nxt_st.sel = 1'b0; // select falls before load: no reload
			nxt_st.st = (cur_ff.op == OP_ERASE) ? H_GAP : H_FIN;
		end
		H_GAP: if (cur_ff.cnt == 24'(GAP_CYCLES - 1)) begin
			nxt_st.cnt = '0;
			nxt_st.st = H_FIN;
		end
		H_FIN: if (half_end) begin
			nxt_st.cnt = '0;
			nxt_st.load = 1'b0;
			nxt_st.sel = 1'b0; // stale select would reload later
			nxt_st.s_wr = 1'b0;
			nxt_st.sdata = 1'b0;
			nxt_st.rd_valid = is_rd;
			nxt_st.busy = 1'b0;
			nxt_st.st = H_IDLE;
		end
		default: nxt_st.st = H_IDLE;
		endcase
	end

	// enable pin starts high until a mode write completes
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			cur_ff <= '0;
			cur_ff.st <= H_IDLE;
			cur_ff.op <= OP_MODE;
			cur_ff.en_n <= 1'b1;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign LINK.sclk = cur_ff.sclk;
	assign LINK.sdata = cur_ff.sdata;
	assign LINK.s_wr = cur_ff.s_wr;
	assign LINK.mode_stb = cur_ff.stb;
	assign LINK.mode_en_n = cur_ff.en_n;
	assign LINK.nv_select = cur_ff.sel;
	assign LINK.nv_load_ctrl = cur_ff.load;
	assign LINK.prog_voltage_neg = cur_ff.vneg;
	assign LINK.prog_voltage_pos = cur_ff.vpos;
	assign BUSY = cur_ff.busy;
	assign RD_VALID = cur_ff.rd_valid;
	assign RD_DATA = cur_ff.sr;
endmodule
`default_nettype wire

// ===== test/pnvc_link_props.sv
// Purpose: pin-level checks on the link between programmer and device
// Assumes: one clock domain; link pins are sampled by CLK_SYS
// Notes: helper counters measure pulse length and erase-to-write gap
`default_nettype none
module pnvc_link_props #(
	parameter int PULSE_CYCLES = 50,
	parameter int GAP_CYCLES = 30
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RESETN, // async reset, active low
	input wire logic sclk, // serial clock
	input wire logic sdata, // serial data
	input wire logic s_wr, // secondary strobe
	input wire logic mode_stb, // mode strobe
	input wire logic mode_en_n, // mode enable, active low
	input wire logic nv_select, // nv select
	input wire logic nv_load_ctrl, // nv load control
	input wire logic prog_voltage_neg, // erase pulse
	input wire logic prog_voltage_pos, // write pulse
	input wire logic sdout // device serial output
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic neg_q;
		logic seen;
		logic [23:0] gap;
		logic [23:0] plen;
	} pnvc_chk_t;
	pnvc_chk_t st_ff;
	pnvc_chk_t nxt_st;
	// gap starts saturated so a write with no erase before it is legal
	always_comb begin
		nxt_st = st_ff;
		nxt_st.neg_q = prog_voltage_neg;
		nxt_st.seen = st_ff.seen | mode_stb;
		if (st_ff.neg_q && !prog_voltage_neg)
			nxt_st.gap = 24'h000000;
		else if (st_ff.gap != 24'hFFFFFF)
			nxt_st.gap = st_ff.gap + 24'h000001;
		nxt_st.plen = (prog_voltage_neg | prog_voltage_pos) ?
			st_ff.plen + 24'h000001 : 24'h000000;
	end
	// helper state register
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			st_ff <= '{1'b0, 1'b0, 24'hFFFFFF, 24'h000000};
		else
			st_ff <= nxt_st;
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);
	a_erase_levels: assert property (prog_voltage_neg |->
		s_wr && nv_select && nv_load_ctrl) else $error("erase levels");
	a_write_levels: assert property (prog_voltage_pos |->
		s_wr && !nv_select && nv_load_ctrl) else $error("write levels");
	a_pulse_overlap: assert property (
		!(prog_voltage_neg && prog_voltage_pos)) else $error("overlap");
	a_pulse_length: assert property (
		($fell(prog_voltage_neg) || $fell(prog_voltage_pos)) |->
		st_ff.plen == 24'(PULSE_CYCLES)) else $error("pulse length");
	a_gap_kept: assert property ($rose(prog_voltage_pos) |->
		st_ff.gap >= 24'(GAP_CYCLES)) else $error("erase gap short");
	a_load_drop: assert property ($fell(prog_voltage_pos) |->
		nv_load_ctrl ##[1:40] !nv_load_ctrl) else $error("load drop");
	a_data_while_low: assert property ($changed(sdata) |->
		!sclk) else $error("data moved with clock high");
	a_sclk_no_strobe: assert property ($rose(sclk) |->
		!s_wr && !prog_voltage_neg && !prog_voltage_pos)
		else $error("clock during nv op");
	a_enable_held: assert property (!st_ff.seen |-> mode_en_n)
		else $error("enable low before mode written");
	a_idle_output: assert property (mode_en_n |-> !sdout)
		else $error("output active while disabled");
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: drives both ends through the host command port
// Assumes: host pulse and gap shortened to 50 and 30 cycles
// Notes: expected values come from literals set here and from pnvc_pkg constants
`default_nettype none
module testbench import pnvc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PULSE_T = 50;
	localparam int GAP_T = 30;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	pnvc_op_t cmd_op = OP_MODE;
	logic [SHADOW_W-1:0] cmd_data = 20'h00000;
	logic main_div = 1'b0;
	logic mod_sel = 1'b0;
	logic ref_div = 1'b0;
	logic cmd_ready, busy, rd_valid, power_down, cnt_load_cont;
	logic [SHADOW_W-1:0] rd_data, store_q, shadow_q;
	logic [SHADOW_W-1:0] rd_word = 20'h00000;
	logic [7:0] sel_tab [3] = '{8'h04, 8'h20, 8'h40};
	logic [7:0] fill_tab [5] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h10};
	int num_errors = 0;
	int checked = 0;
	int rd_cnt = 0;
	pnvc_link_if link();
	pnvc_dev i_pnvc_dev(.CLK_SYS(clk_sys), .RESETN(resetn), .LINK(link),
		.MAIN_DIV_OUT(main_div), .MODULUS_SELECT(mod_sel),
		.REF_DIV_OUT(ref_div), .POWER_DOWN(power_down),
		.CNT_LOAD_CONT(cnt_load_cont), .STORE_Q(store_q),
		.SHADOW_Q(shadow_q));
	pnvc_host #(.PULSE_CYCLES(PULSE_T), .GAP_CYCLES(GAP_T)) i_pnvc_host(
		.CLK_SYS(clk_sys), .RESETN(resetn), .LINK(link),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
		.CMD_DATA(cmd_data), .BUSY(busy), .RD_VALID(rd_valid),
		.RD_DATA(rd_data));
	pnvc_link_props #(.PULSE_CYCLES(PULSE_T), .GAP_CYCLES(GAP_T))
		i_pnvc_link_props(.CLK_SYS(clk_sys), .RESETN(resetn),
		.sclk(link.sclk), .sdata(link.sdata), .s_wr(link.s_wr),
		.mode_stb(link.mode_stb), .mode_en_n(link.mode_en_n),
		.nv_select(link.nv_select), .nv_load_ctrl(link.nv_load_ctrl),
		.prog_voltage_neg(link.prog_voltage_neg),
		.prog_voltage_pos(link.prog_voltage_pos), .sdout(link.sdout));
	// 125 MHz system clock
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	// readback word is only valid in its one-cycle pulse
	always @(posedge clk_sys) if (rd_valid === 1'b1) begin
		rd_word <= rd_data;
		rd_cnt <= rd_cnt + 1;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [SHADOW_W-1:0] exp,
		input logic [SHADOW_W-1:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// offer held until ready is seen high, so a full queue loses nothing
	task automatic send(input pnvc_op_t op, input logic [SHADOW_W-1:0] d);
		int n;
		n = 0;
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_ready !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			chk("ready_timeout", 20'h00001, 20'h00000);
			end_sim();
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask
	// idle means busy low for eight cycles, longer than gaps between ops
	task automatic wait_idle;
		int n, q;
		n = 0;
		q = 0;
		while (q < 8) begin
			@(negedge clk_sys);
			q = (busy === 1'b0) ? q + 1 : 0;
			n++;
			if (n > 20000) begin
				chk("busy_timeout", 20'h00000, 20'h00001);
				end_sim();
			end
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		chk("store", STORE_ERASED, store_q);
		chk("shadow", SHADOW_RESET, shadow_q);
		chk("ready", 20'h00001, 20'(cmd_ready));
		chk("power_down", 20'h00000, 20'(power_down));
		$display("test reset done");
		foreach (fill_tab[i]) send(OP_MODE, 20'(fill_tab[i]));
		chk("fifo_full", 20'h00000, 20'(cmd_ready));
		send(OP_MODE, 20'h00099);
		wait_idle();
		chk("power_down", 20'h00001, 20'(power_down));
		chk("cnt_load", 20'h00001, 20'(cnt_load_cont));
		send(OP_MODE, 20'h00008);
		repeat (100) @(negedge clk_sys);
		chk("cnt_load_mid", 20'h00001, 20'(cnt_load_cont));
		wait_idle();
		chk("cnt_load", 20'h00000, 20'(cnt_load_cont));
		chk("power_down", 20'h00001, 20'(power_down));
		$display("test mode done");
		for (int k = 0; k < 3; k++) begin
			send(OP_MODE, 20'(sel_tab[k]));
			wait_idle();
			for (int v = 0; v < 2; v++) begin
				@(negedge clk_sys);
				main_div = v[0] ^ (k != 0);
				mod_sel = v[0] ^ (k != 1);
				ref_div = v[0] ^ (k != 2);
				repeat (10) @(negedge clk_sys);
				chk("sdout", 20'(v[0]), 20'(link.sdout));
			end
		end
		$display("test routing done");
		send(OP_SHADOW, 20'h5A3C1);
		wait_idle();
		chk("shadow", 20'h5A3C1, shadow_q);
		send(OP_ERASE, 20'h00000);
		wait_idle();
		chk("store", STORE_ERASED, store_q);
		send(OP_PROG, 20'h00000);
		wait_idle();
		chk("store", 20'h5A3C1, store_q);
		send(OP_SHADOW, 20'h0F0F0);
		send(OP_PROG, 20'h00000);
		wait_idle();
		chk("store", 20'h5A3C1 & 20'h0F0F0, store_q);
		$display("test program done");
		send(OP_MODE, 20'h00002);
		send(OP_READ, 20'h00000);
		wait_idle();
		chk("rd_count", 20'h00001, 20'(rd_cnt));
		chk("rd_word", 20'h5A3C1 & 20'h0F0F0, rd_word);
		$display("test readback done");
		send(OP_ERASE, 20'h00000);
		wait_idle();
		chk("store", STORE_ERASED, store_q);
		send(OP_READ, 20'h00000);
		wait_idle();
		chk("rd_count", 20'h00002, 20'(rd_cnt));
		chk("rd_word", STORE_ERASED, rd_word);
		$display("test erase done");
		end_sim();
	end
endmodule
`default_nettype wire
